// [hdl/rps_pkg.sv]
// constants, field layout and source codes for the pin routing block
// assumes a 40 MHz clock and a classic wishbone master with 32-bit data
package rps_pkg;
  // register indices; byte address is four times the index
  localparam logic [7:0] RPS_IDX_PINCFG = 8'h00;
  localparam logic [7:0] RPS_IDX_PINSTAT = 8'h01;
  localparam logic [7:0] RPS_IDX_EVSTAT = 8'h02;
  localparam logic [7:0] RPS_IDX_EVMASK = 8'h03;
  localparam logic [7:0] RPS_IDX_CONTROL2 = 8'h11;
  localparam logic [7:0] RPS_IDX_SQW = 8'h13;
  localparam int RPS_ADR_W = 10;
  // pin configuration fields
  localparam int RPS_CFG_E1_EN = 0;
  localparam int RPS_CFG_E1_POL = 1;
  localparam int RPS_CFG_E2_EN = 2;
  localparam int RPS_CFG_E2_POL = 3;
  localparam int RPS_CFG_XR_EN = 4;
  localparam int RPS_CFG_RST_POL = 5;
  localparam int RPS_CFG_SW_EN = 6;
  // pin status fields
  localparam int RPS_ST_E_LVL = 0;
  localparam int RPS_ST_WD_LVL = 1;
  localparam int RPS_ST_CSEL = 2;
  localparam int RPS_ST_RSTA = 3;
  // event bits, shared by status and mask
  localparam int RPS_EV_EXT1 = 0;
  localparam int RPS_EV_EXT2 = 1;
  localparam int RPS_EV_KICK = 2;
  localparam int RPS_EV_XRST = 3;
  localparam int RPS_EV_W = 4;
  // control2 fields
  localparam int RPS_C2_PSEL_LO = 0;
  localparam int RPS_C2_SSEL_LO = 2;
  localparam int RPS_C2_OUT = 5;
  localparam int RPS_C2_LVL2 = 6;
  // square wave register field
  localparam int RPS_SQ_EN = 7;
  // reset values
  localparam logic [7:0] RPS_RST_PINCFG = 8'h00;
  localparam logic [7:0] RPS_RST_CONTROL2 = 8'h60;
  localparam logic [7:0] RPS_RST_SQW = 8'h00;
  localparam logic [RPS_EV_W-1:0] RPS_RST_EVMASK = 4'h0;
  typedef enum logic [1:0] {
    RPS_P_LEVEL = 2'b00,
    RPS_P_NIRQ = 2'b01,
    RPS_P_SQW = 2'b10,
    RPS_P_NAIRQ = 2'b11
  } rps_psel_e;
  typedef enum logic [2:0] {
    RPS_S_LEVEL = 3'b000,
    RPS_S_SQW = 3'b001,
    RPS_S_NIRQ = 3'b010,
    RPS_S_NAIRQ = 3'b011,
    RPS_S_TMR = 3'b100,
    RPS_S_NTMR = 3'b101,
    RPS_S_PSW = 3'b110,
    RPS_S_RSVD = 3'b111
  } rps_ssel_e;
endpackage : rps_pkg

// [hdl/rps_pin_event.sv]
// edge watcher for one synchronous input pin
// assumes the pin already changes in step with clk
module rps_pin_event (
  input wire logic clk, // block clock
  input wire logic rst, // async reset, high
  input wire logic pin, // pin level
  input wire logic enable, // event enable
  input wire logic polarity, // 1 rising, 0 falling
  output logic level, // registered pin level
  output logic activePulse, // one cycle on active edge
  output logic anyEdge // one cycle on any edge
);
  // remember the pin one cycle back
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      level <= 1'b0;
    end else begin
      level <= pin;
    end
  end
  // edge pulses, enable gates only the active one
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      activePulse <= 1'b0;
      anyEdge <= 1'b0;
    end else begin
      activePulse <= enable && (pin != level) && (pin == polarity);
      anyEdge <= (pin != level);
    end
  end
endmodule : rps_pin_event

// [hdl/rps_od_driver.sv]
// open-drain pad driver: pulls low or lets go
// assumes an external pull-up decides the released level
module rps_od_driver #(
  parameter logic RESET_OE = 1'b0
) (
  input wire logic clk, // block clock
  input wire logic rst, // async reset, high
  input wire logic level, // wanted pin level
  output logic padOut, // pad data, always low
  output logic padOe // high while pulling low
);
  // never drive high: data stays zero, enable carries the level
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      padOut <= 1'b0;
      padOe <= RESET_OE;
    end else begin
      padOut <= 1'b0;
      padOe <= !level;
    end
  end
endmodule : rps_od_driver

// [hdl/rps_pin_routing.sv]
// pin routing for the clock chip: inputs, interrupt pins, reset, select
// assumes a classic wishbone master and core signals synchronous to clk
module rps_pin_routing (
  input wire logic clk, // 40 MHz clock
  input wire logic rst, // async reset, high
  input wire logic wb_cyc_i, // bus cycle
  input wire logic wb_stb_i, // bus strobe
  input wire logic wb_we_i, // write
  input wire logic [rps_pkg::RPS_ADR_W-1:0] wb_adr_i, // byte address
  input wire logic [3:0] wb_sel_i, // byte enables
  input wire logic [31:0] wb_dat_i, // write data
  output logic [31:0] wb_dat_o, // read data
  output logic wb_ack_o, // acknowledge
  input wire logic extInterruptPin, // external interrupt pin
  input wire logic watchdogKickPin, // watchdog input pin
  input wire logic extResetInN, // external reset input, low
  input wire logic chipSelectN, // serial select, low
  input wire logic serialDataIn, // serial data pin
  input wire logic coreIrq, // combined interrupt, high
  input wire logic alarmInterrupt, // alarm interrupt, high
  input wire logic timerInterrupt, // timer interrupt, high
  input wire logic squareWave, // square wave from divider
  input wire logic coreResetReq, // other reset sources, high
  input wire logic deviceReady, // core out of reset, port usable
  input wire logic sleepPowerOn, // sleep control closes switch
  output logic primaryIrqPinOut, // primary pin data
  output logic primaryIrqPinOe, // primary pin pull-low
  output logic secondaryIrqSwitchPinOut, // secondary pin data
  output logic secondaryIrqSwitchPinOe, // secondary pin pull-low
  output logic secondaryLowOhm, // secondary pin in switch mode
  output logic timerIrqPinOut, // timer pin data
  output logic timerIrqPinOe, // timer pin pull-low
  output logic squareWavePin, // push-pull clock pin
  output logic resetPinOut, // reset pin data
  output logic resetPinOe, // reset pin pull-low
  output logic extFirstIrq, // first external event pulse
  output logic extSecondIrq, // second external event pulse
  output logic watchdogKick, // watchdog kick pulse
  output logic serialSelected, // serial engine selected
  output logic serialDataGated, // serial data while selected
  output logic irq // level interrupt
);
  import rps_pkg::*;

  // byte addresses of the registers
  localparam logic [RPS_ADR_W-1:0] ADR_PINCFG = {RPS_IDX_PINCFG, 2'b00};
  localparam logic [RPS_ADR_W-1:0] ADR_PINSTAT = {RPS_IDX_PINSTAT, 2'b00};
  localparam logic [RPS_ADR_W-1:0] ADR_EVSTAT = {RPS_IDX_EVSTAT, 2'b00};
  localparam logic [RPS_ADR_W-1:0] ADR_EVMASK = {RPS_IDX_EVMASK, 2'b00};
  localparam logic [RPS_ADR_W-1:0] ADR_CONTROL2 = {RPS_IDX_CONTROL2, 2'b00};
  localparam logic [RPS_ADR_W-1:0] ADR_SQW = {RPS_IDX_SQW, 2'b00};

  // software registers
  logic [7:0] pinCfg;
  logic [7:0] control2;
  logic [7:0] sqwReg;
  logic [RPS_EV_W-1:0] evStat;
  logic [RPS_EV_W-1:0] evMask;

  // bus decode
  logic busReq;
  logic wrLow;
  logic rdEvStat;
  logic [31:0] next_rdData;

  // pin side
  logic extLevel;
  logic extPulse;
  logic wdLevel;
  logic wdPulse;
  logic wdEdge;
  logic extResetPrevN;
  logic extResetEvent;
  logic resetAssert;
  logic resetLevel;
  logic primaryLevel;
  logic secondaryLevel;
  logic [RPS_EV_W-1:0] evIn;

  // named fields
  logic ext1Enable;
  logic ext1Polarity;
  logic ext2Enable;
  logic ext2Polarity;
  logic extResetEnable;
  logic resetPolarity;
  logic powerSwitchEnable;
  logic squareWaveEnable;
  logic levelBit;
  logic secondaryLevelBit;
  rps_psel_e primarySel;
  rps_ssel_e secondarySel;

  assign ext1Enable = pinCfg[RPS_CFG_E1_EN];
  assign ext1Polarity = pinCfg[RPS_CFG_E1_POL];
  assign ext2Enable = pinCfg[RPS_CFG_E2_EN];
  assign ext2Polarity = pinCfg[RPS_CFG_E2_POL];
  assign extResetEnable = pinCfg[RPS_CFG_XR_EN];
  assign resetPolarity = pinCfg[RPS_CFG_RST_POL];
  assign powerSwitchEnable = pinCfg[RPS_CFG_SW_EN];
  assign squareWaveEnable = sqwReg[RPS_SQ_EN];
  assign levelBit = control2[RPS_C2_OUT];
  assign secondaryLevelBit = control2[RPS_C2_LVL2];
  assign primarySel = rps_psel_e'(control2[RPS_C2_PSEL_LO +: 2]);
  assign secondarySel = rps_ssel_e'(control2[RPS_C2_SSEL_LO +: 3]);

  // a request is taken once, in the cycle before ack rises
  assign busReq = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wrLow = busReq && wb_we_i && wb_sel_i[0];
  assign rdEvStat = busReq && !wb_we_i && (wb_adr_i == ADR_EVSTAT);

  // acknowledge every request one cycle after it is seen
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= busReq;
    end
  end

  // read multiplexer, unmapped addresses read zero
  always_comb begin
    next_rdData = 32'h0000_0000;
    case (wb_adr_i)
      ADR_PINCFG: next_rdData[7:0] = pinCfg;
      ADR_PINSTAT: begin
        next_rdData[RPS_ST_E_LVL] = extLevel;
        next_rdData[RPS_ST_WD_LVL] = wdLevel;
        next_rdData[RPS_ST_CSEL] = serialSelected;
        next_rdData[RPS_ST_RSTA] = resetAssert;
      end
      ADR_EVSTAT: next_rdData[RPS_EV_W-1:0] = evStat;
      ADR_EVMASK: next_rdData[RPS_EV_W-1:0] = evMask;
      ADR_CONTROL2: next_rdData[7:0] = control2;
      ADR_SQW: next_rdData[7:0] = sqwReg;
      default: next_rdData = 32'h0000_0000;
    endcase
  end

  // read data register, held until the next read
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wb_dat_o <= 32'h0000_0000;
    end else if (busReq && !wb_we_i) begin
      wb_dat_o <= next_rdData;
    end
  end

  // pin configuration register
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pinCfg <= RPS_RST_PINCFG;
    end else if (wrLow && (wb_adr_i == ADR_PINCFG)) begin
      pinCfg <= wb_dat_i[7:0];
    end
  end

  // output select register
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      control2 <= RPS_RST_CONTROL2;
    end else if (wrLow && (wb_adr_i == ADR_CONTROL2)) begin
      control2 <= wb_dat_i[7:0];
    end
  end

  // square wave enable register
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sqwReg <= RPS_RST_SQW;
    end else if (wrLow && (wb_adr_i == ADR_SQW)) begin
      sqwReg <= wb_dat_i[7:0];
    end
  end

  // interrupt mask register
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      evMask <= RPS_RST_EVMASK;
    end else if (wrLow && (wb_adr_i == ADR_EVMASK)) begin
      evMask <= wb_dat_i[RPS_EV_W-1:0];
    end
  end

  // external interrupt pin watcher
  rps_pin_event u_ext_event (
    .clk(clk),
    .rst(rst),
    .pin(extInterruptPin),
    .enable(ext1Enable),
    .polarity(ext1Polarity),
    .level(extLevel),
    .activePulse(extPulse),
    .anyEdge()
  );

  // watchdog pin watcher
  rps_pin_event u_wd_event (
    .clk(clk),
    .rst(rst),
    .pin(watchdogKickPin),
    .enable(ext2Enable),
    .polarity(ext2Polarity),
    .level(wdLevel),
    .activePulse(wdPulse),
    .anyEdge(wdEdge)
  );

  // event pulses toward the core
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      extFirstIrq <= 1'b0;
      extSecondIrq <= 1'b0;
      watchdogKick <= 1'b0;
    end else begin
      extFirstIrq <= extPulse;
      extSecondIrq <= wdPulse;
      watchdogKick <= wdEdge;
    end
  end

  // external reset falling edge while enabled
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      extResetPrevN <= 1'b1;
    end else begin
      extResetPrevN <= extResetInN;
    end
  end
  assign extResetEvent = extResetEnable && extResetPrevN && !extResetInN;

  // sticky events, a read clears them but a new event wins
  assign evIn = {extResetEvent, wdEdge, wdPulse, extPulse};
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      evStat <= '0;
    end else begin
      evStat <= (rdEvStat ? '0 : evStat) | evIn;
    end
  end

  // level interrupt from unmasked events
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      irq <= 1'b0;
    end else begin
      irq <= |(evStat & evMask);
    end
  end

  // reset output, level chosen by polarity bit
  assign resetAssert = coreResetReq || (extResetEnable && !extResetInN);
  assign resetLevel = resetPolarity ? resetAssert : !resetAssert;

  rps_od_driver #(
    .RESET_OE(1'b0)
  ) u_reset_od (
    .clk(clk),
    .rst(rst),
    .level(resetLevel),
    .padOut(resetPinOut),
    .padOe(resetPinOe)
  );

  // primary pin source, held low until the device is reachable
  always_comb begin
    case (primarySel)
      RPS_P_LEVEL: primaryLevel = levelBit;
      RPS_P_NIRQ: primaryLevel = !coreIrq;
      RPS_P_SQW: primaryLevel = squareWaveEnable ? squareWave : levelBit;
      RPS_P_NAIRQ: primaryLevel = !alarmInterrupt;
      default: primaryLevel = levelBit;
    endcase
    if (!deviceReady) begin
      primaryLevel = 1'b0;
    end
  end

  rps_od_driver #(
    .RESET_OE(1'b1)
  ) u_primary_od (
    .clk(clk),
    .rst(rst),
    .level(primaryLevel),
    .padOut(primaryIrqPinOut),
    .padOe(primaryIrqPinOe)
  );

  // secondary pin source, or power switch
  always_comb begin
    case (secondarySel)
      RPS_S_LEVEL: secondaryLevel = secondaryLevelBit;
      RPS_S_SQW: secondaryLevel = squareWaveEnable ? squareWave : secondaryLevelBit;
      RPS_S_NIRQ: secondaryLevel = !coreIrq;
      RPS_S_NAIRQ: secondaryLevel = !alarmInterrupt;
      RPS_S_TMR: secondaryLevel = timerInterrupt;
      RPS_S_NTMR: secondaryLevel = !timerInterrupt;
      RPS_S_PSW: secondaryLevel = !sleepPowerOn;
      default: secondaryLevel = secondaryLevelBit;
    endcase
    if (powerSwitchEnable) begin
      secondaryLevel = !sleepPowerOn;
    end
  end

  rps_od_driver #(
    .RESET_OE(1'b0)
  ) u_secondary_od (
    .clk(clk),
    .rst(rst),
    .level(secondaryLevel),
    .padOut(secondaryIrqSwitchPinOut),
    .padOe(secondaryIrqSwitchPinOe)
  );

  // switch mode flag for the pad strength
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      secondaryLowOhm <= 1'b0;
    end else begin
      secondaryLowOhm <= powerSwitchEnable;
    end
  end

  // timer pin, fixed active-low timer interrupt
  rps_od_driver #(
    .RESET_OE(1'b0)
  ) u_timer_od (
    .clk(clk),
    .rst(rst),
    .level(!timerInterrupt),
    .padOut(timerIrqPinOut),
    .padOe(timerIrqPinOe)
  );

  // push-pull clock pin
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      squareWavePin <= 1'b0;
    end else begin
      squareWavePin <= squareWaveEnable ? squareWave : levelBit;
    end
  end

  // serial select and gated data
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      serialSelected <= 1'b0;
      serialDataGated <= 1'b0;
    end else begin
      serialSelected <= !chipSelectN;
      serialDataGated <= !chipSelectN && serialDataIn;
    end
  end
endmodule : rps_pin_routing

// [bench/rps_pin_routing_props.sv]
// concurrent checks on the pin routing block, bound to its top module
// assumes registers change only through the wishbone port
module rps_pin_routing_props
  import rps_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [rps_pkg::RPS_ADR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic wb_ack_o,
  input wire logic extInterruptPin,
  input wire logic watchdogKickPin,
  input wire logic extResetInN,
  input wire logic chipSelectN,
  input wire logic coreIrq,
  input wire logic alarmInterrupt,
  input wire logic timerInterrupt,
  input wire logic squareWave,
  input wire logic coreResetReq,
  input wire logic deviceReady,
  input wire logic sleepPowerOn,
  input wire logic primaryIrqPinOut,
  input wire logic primaryIrqPinOe,
  input wire logic secondaryIrqSwitchPinOut,
  input wire logic secondaryIrqSwitchPinOe,
  input wire logic secondaryLowOhm,
  input wire logic timerIrqPinOut,
  input wire logic timerIrqPinOe,
  input wire logic squareWavePin,
  input wire logic resetPinOut,
  input wire logic resetPinOe,
  input wire logic extFirstIrq,
  input wire logic extSecondIrq,
  input wire logic watchdogKick,
  input wire logic serialSelected
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] cfg;
  logic [7:0] ctl;
  logic sqe;
  logic take;
  logic pLvl;
  logic sLvl;
  assign take = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && wb_sel_i[0];
  // shadow copies of the writable routing registers
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cfg <= RPS_RST_PINCFG;
      ctl <= RPS_RST_CONTROL2;
      sqe <= 1'b0;
    end else if (take) begin
      if (wb_adr_i == {RPS_IDX_PINCFG, 2'b00}) cfg <= wb_dat_i[7:0];
      if (wb_adr_i == {RPS_IDX_CONTROL2, 2'b00}) ctl <= wb_dat_i[7:0];
      if (wb_adr_i == {RPS_IDX_SQW, 2'b00}) sqe <= wb_dat_i[RPS_SQ_EN];
    end
  end
  // wanted levels of the two selectable pins
  always_comb begin
    case (ctl[1:0])
      2'd0: pLvl = ctl[RPS_C2_OUT];
      2'd1: pLvl = !coreIrq;
      2'd2: pLvl = sqe ? squareWave : ctl[RPS_C2_OUT];
      default: pLvl = !alarmInterrupt;
    endcase
    case (ctl[4:2])
      3'd1: sLvl = sqe ? squareWave : ctl[RPS_C2_LVL2];
      3'd2: sLvl = !coreIrq;
      3'd3: sLvl = !alarmInterrupt;
      3'd4: sLvl = timerInterrupt;
      3'd5: sLvl = !timerInterrupt;
      3'd6: sLvl = !sleepPowerOn;
      default: sLvl = ctl[RPS_C2_LVL2];
    endcase
    if (cfg[RPS_CFG_SW_EN]) sLvl = !sleepPowerOn;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  a_od_never_high: assert property (
    !(primaryIrqPinOut | secondaryIrqSwitchPinOut | timerIrqPinOut | resetPinOut))
    else $error("open-drain pad drives high");
  a_primary_route: assert property (
    !$past(rst) |-> primaryIrqPinOe == !$past(deviceReady && pLvl))
    else $error("primary pin wrong");
  a_secondary_route: assert property (
    !$past(rst) |-> secondaryIrqSwitchPinOe == !$past(sLvl))
    else $error("secondary pin wrong");
  a_switch_mode: assert property (
    !$past(rst) |-> secondaryLowOhm == $past(cfg[RPS_CFG_SW_EN]))
    else $error("switch mode flag wrong");
  a_timer_pin: assert property (
    !$past(rst) |-> timerIrqPinOe == $past(timerInterrupt))
    else $error("timer pin wrong");
  a_clock_pin: assert property (
    !$past(rst) |-> squareWavePin == $past(sqe ? squareWave : ctl[RPS_C2_OUT]))
    else $error("clock pin wrong");
  a_reset_pin: assert property (
    !$past(rst) |-> resetPinOe == $past(cfg[5] ^ (coreResetReq | (cfg[4] & !extResetInN))))
    else $error("reset pin wrong");
  a_select_follow: assert property (
    $changed(chipSelectN) |=> serialSelected == !$past(chipSelectN))
    else $error("select not followed");
  a_ext1_event: assert property (
    (cfg[0] && (cfg[1] ? $rose(extInterruptPin) : $fell(extInterruptPin))) |-> ##[2:3] extFirstIrq)
    else $error("first event missing");
  a_ext2_event: assert property (
    (cfg[2] && (cfg[3] ? $rose(watchdogKickPin) : $fell(watchdogKickPin))) |-> ##[2:3] extSecondIrq)
    else $error("second event missing");
  a_kick_event: assert property (
    $changed(watchdogKickPin) |-> ##[2:3] watchdogKick)
    else $error("kick missing");
  c_first: cover property (extFirstIrq);
  c_second_kick: cover property (extSecondIrq && watchdogKick);
  c_switch: cover property (secondaryLowOhm && secondaryIrqSwitchPinOe);
endmodule : rps_pin_routing_props

bind rps_pin_routing rps_pin_routing_props u_props (.*);

// [bench/rps_host_model.sv]
// host side: pull-ups on the open-drain wires and the serial select
// assumes pad enables come straight from the routing block
module rps_host_model (
  input wire logic clk, // block clock
  input wire logic primaryOe, // primary pad pulls low
  input wire logic secondaryOe, // secondary pad pulls low
  input wire logic timerOe, // timer pad pulls low
  input wire logic resetOe, // reset pad pulls low
  input wire logic hostSelect, // host wants the device
  input wire logic hostData, // bit the host sends
  output logic primaryLine, // primary wire
  output logic secondaryLine, // secondary wire
  output logic timerLine, // timer wire
  output logic resetLine, // reset wire
  output logic chipSelectN, // select, low active
  output logic serialDataIn // serial data wire
);
  timeunit 1ns;
  timeprecision 1ps;
  logic lastData = 1'b0;
  // a released pad leaves the wire to its pull-up
  assign primaryLine = primaryOe ? 1'b0 : 1'b1;
  assign secondaryLine = secondaryOe ? 1'b0 : 1'b1;
  assign timerLine = timerOe ? 1'b0 : 1'b1;
  assign resetLine = resetOe ? 1'b0 : 1'b1;
  assign chipSelectN = !hostSelect;
  // unselected data wire shows the inverse of the last bit sent
  always_ff @(posedge clk) begin
    if (hostSelect) lastData <= hostData;
  end
  assign serialDataIn = hostSelect ? hostData : !lastData;
endmodule : rps_host_model

// [bench/tb_rps_pin_routing.sv]
// self-checking bench for the pin routing block
// assumes the host model and checker files are compiled alongside
module tb_rps_pin_routing;
  import rps_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [9:0] ADR_CFG = {RPS_IDX_PINCFG, 2'b00};
  localparam logic [9:0] ADR_STAT = {RPS_IDX_PINSTAT, 2'b00};
  localparam logic [9:0] ADR_EV = {RPS_IDX_EVSTAT, 2'b00};
  localparam logic [9:0] ADR_MASK = {RPS_IDX_EVMASK, 2'b00};
  localparam logic [9:0] ADR_C2 = {RPS_IDX_CONTROL2, 2'b00};
  localparam logic [9:0] ADR_SQW = {RPS_IDX_SQW, 2'b00};
  logic clk = 1'b0, rst = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [9:0] adr = '0;
  logic [3:0] sel = 4'h0;
  logic [31:0] datW = '0, datR, rd;
  logic extPin = 1'b0, wdPin = 1'b0, extRstN = 1'b1, coreIrq = 1'b0, alarm = 1'b0;
  logic timerIrq = 1'b0, sqWave = 1'b0, coreRst = 1'b0, ready = 1'b0, sleepOn = 1'b0;
  logic hostSel = 1'b0, hostData = 1'b0, b;
  logic ack, csN, sdIn, pLine, sLine, tLine, rLine, pOe, sOe, tOe, rOe;
  logic lowOhm, sqPin, selOut, gated, irq;
  int errorCnt = 0, compares = 0;
  always #12.5 clk = ~clk;
  rps_pin_routing u_dut (.clk(clk), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(datW), .wb_dat_o(datR),
    .wb_ack_o(ack), .extInterruptPin(extPin), .watchdogKickPin(wdPin),
    .extResetInN(extRstN), .chipSelectN(csN), .serialDataIn(sdIn), .coreIrq(coreIrq),
    .alarmInterrupt(alarm), .timerInterrupt(timerIrq), .squareWave(sqWave),
    .coreResetReq(coreRst), .deviceReady(ready), .sleepPowerOn(sleepOn),
    .primaryIrqPinOut(), .primaryIrqPinOe(pOe), .secondaryIrqSwitchPinOut(),
    .secondaryIrqSwitchPinOe(sOe), .secondaryLowOhm(lowOhm), .timerIrqPinOut(),
    .timerIrqPinOe(tOe), .squareWavePin(sqPin), .resetPinOut(), .resetPinOe(rOe),
    .extFirstIrq(), .extSecondIrq(), .watchdogKick(), .serialSelected(selOut),
    .serialDataGated(gated), .irq(irq));
  rps_host_model u_host (.clk(clk), .primaryOe(pOe), .secondaryOe(sOe), .timerOe(tOe),
    .resetOe(rOe), .hostSelect(hostSel), .hostData(hostData), .primaryLine(pLine),
    .secondaryLine(sLine), .timerLine(tLine), .resetLine(rLine), .chipSelectN(csN),
    .serialDataIn(sdIn));
  task automatic stopTest;
    $display("errors %0d compares %0d", errorCnt, compares);
    if (errorCnt == 0 && compares > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : stopTest
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      errorCnt++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick
  // one classic wishbone cycle, released after ack is sampled
  task automatic wbCycle(input logic w, input logic [9:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    datW <= d;
    sel <= 4'hf;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 20);
    if (n >= 20) chk("ack", 32'h1, 32'h0);
    rd = datR;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask : wbCycle
  task automatic rdChk(input string nm, input logic [9:0] a, input logic [31:0] e);
    wbCycle(1'b0, a, 32'h0);
    chk(nm, e, rd);
  endtask : rdChk
  // hang guard
  initial begin
    #(25 * 6000);
    errorCnt++;
    stopTest();
  end
  // main sequence
  initial begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    tick(2);
    chk("primary held", 32'h0, 32'(pLine));
    chk("reset idle", 32'h1, 32'(rLine));
    rdChk("cfg rst", ADR_CFG, 32'(RPS_RST_PINCFG));
    rdChk("c2 rst", ADR_C2, 32'h60);
    rdChk("sqw rst", ADR_SQW, 32'h0);
    rdChk("mask rst", ADR_MASK, 32'h0);
    chk("primary held", 32'h0, 32'(pLine));
    @(posedge clk);
    ready <= 1'b1;
    tick(3);
    chk("primary ready", 32'h1, 32'(pLine));
    wbCycle(1'b1, 10'h200, 32'hff);
    rdChk("unmapped", 10'h200, 32'h0);
    // pin levels and select readback
    @(posedge clk);
    extPin <= 1'b1;
    hostSel <= 1'b1;
    hostData <= 1'b1;
    tick(3);
    rdChk("stat a", ADR_STAT, 32'h5);
    chk("gated on", 32'h1, 32'(gated));
    @(posedge clk);
    extPin <= 1'b0;
    wdPin <= 1'b1;
    hostSel <= 1'b0;
    tick(3);
    rdChk("stat b", ADR_STAT, 32'h2);
    chk("gated off", 32'h0, 32'(gated));
    chk("sel off", 32'h0, 32'(selOut));
    rdChk("kick only", ADR_EV, 32'h4);
    rdChk("ev clr", ADR_EV, 32'h0);
    // events: first on rising, second on falling, mask 0x3
    wbCycle(1'b1, ADR_CFG, 32'h07);
    wbCycle(1'b1, ADR_MASK, 32'h03);
    rdChk("cfg rd", ADR_CFG, 32'h07);
    @(posedge clk);
    extPin <= 1'b1;
    tick(5);
    chk("irq up", 32'h1, 32'(irq));
    rdChk("ev1", ADR_EV, 32'h1);
    tick(2);
    chk("irq clr", 32'h0, 32'(irq));
    @(posedge clk);
    wdPin <= 1'b0;
    tick(5);
    rdChk("ev2 kick", ADR_EV, 32'h6);
    @(posedge clk);
    extPin <= 1'b0;
    tick(5);
    rdChk("wrong edge", ADR_EV, 32'h0);
    @(posedge clk);
    wdPin <= 1'b1;
    tick(5);
    chk("masked", 32'h0, 32'(irq));
    rdChk("kick ev", ADR_EV, 32'h4);
    // reset output and its polarity
    wbCycle(1'b1, ADR_CFG, 32'h10);
    @(posedge clk);
    extRstN <= 1'b0;
    tick(3);
    chk("rst low", 32'h0, 32'(rLine));
    rdChk("stat rst", ADR_STAT, 32'ha);
    wbCycle(1'b1, ADR_CFG, 32'h30);
    tick(3);
    chk("rst pol", 32'h1, 32'(rLine));
    @(posedge clk);
    extRstN <= 1'b1;
    tick(3);
    chk("rst pol off", 32'h0, 32'(rLine));
    wbCycle(1'b1, ADR_CFG, 32'h00);
    tick(3);
    chk("rst free", 32'h1, 32'(rLine));
    @(posedge clk);
    coreRst <= 1'b1;
    tick(3);
    chk("core rst", 32'h0, 32'(rLine));
    @(posedge clk);
    coreRst <= 1'b0;
    rdChk("xrst ev", ADR_EV, 32'h8);
    // timer pin and clock pin
    @(posedge clk);
    timerIrq <= 1'b1;
    tick(3);
    chk("timer low", 32'h0, 32'(tLine));
    @(posedge clk);
    timerIrq <= 1'b0;
    tick(3);
    chk("timer free", 32'h1, 32'(tLine));
    chk("clk lvl", 32'h1, 32'(sqPin));
    wbCycle(1'b1, ADR_SQW, 32'h80);
    tick(3);
    chk("clk sqw0", 32'h0, 32'(sqPin));
    @(posedge clk);
    sqWave <= 1'b1;
    tick(3);
    chk("clk sqw1", 32'h1, 32'(sqPin));
    // every select code, with inputs set then inverted
    for (int k = 0; k < 2; k++) begin
      b = k[0];
      @(posedge clk);
      coreIrq <= !b;
      alarm <= b;
      timerIrq <= !b;
      sleepOn <= b;
      sqWave <= !b;
      for (int i = 0; i < 8; i++) begin
        wbCycle(1'b1, ADR_C2, {25'h0, b, b, i[2:0], i[1:0]});
        tick(3);
        chk("primary sel", 32'(4'b1100 >> i[1:0] & 1'b1 ^ b), 32'(pLine));
        chk("second sel", 32'(8'h5a >> i & 1'b1 ^ b), 32'(sLine));
      end
    end
    // power switch mode
    wbCycle(1'b1, ADR_CFG, 32'h40);
    @(posedge clk);
    sleepOn <= 1'b1;
    tick(3);
    chk("low ohm", 32'h1, 32'(lowOhm));
    chk("switch on", 32'h0, 32'(sLine));
    @(posedge clk);
    sleepOn <= 1'b0;
    tick(3);
    chk("switch off", 32'h1, 32'(sLine));
    stopTest();
  end
endmodule : tb_rps_pin_routing
